//--- rtl/dpc_top.sv
// Table-based defective pixel corrector with staging, active and persistent tables.
// Assumes a pixel stream synchronous to core_clk, contiguous within a row, and an APB master.
`timescale 1ns/100ps
`default_nettype none
module dpc_top #(
    parameter int DEPTH = dpc_pkg::DPC_DEPTH,
    parameter int FACTORY_CNT = dpc_pkg::DPC_FACT_CNT,
    parameter logic [DEPTH*dpc_pkg::DPC_CRD_W-1:0] FACTORY_X = '0,
    parameter logic [DEPTH*dpc_pkg::DPC_CRD_W-1:0] FACTORY_Y = '0
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic nv_init_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dpc_pkg::dpc_pix_t pix_in,
    input wire logic [dpc_pkg::DPC_CRD_W-1:0] roi_off_x,
    input wire logic [dpc_pkg::DPC_CRD_W-1:0] roi_off_y,
    output dpc_pkg::dpc_pix_t pix_out
);
    import dpc_pkg::*;
    localparam int IDX_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int CW = DPC_CRD_W;
    localparam int PW = DPC_PIX_W;

    // Register file state.
    logic en_reg;
    dpc_mode_t mode_reg;
    logic [CNT_W-1:0] sel_reg;
    logic [CNT_W-1:0] stg_cnt_reg;
    logic [CNT_W-1:0] act_cnt_reg;
    logic [CNT_W-1:0] pers_cnt_reg;
    logic [CW-1:0] stg_x [DEPTH];
    logic [CW-1:0] stg_y [DEPTH];
    logic [CW-1:0] act_x [DEPTH];
    logic [CW-1:0] act_y [DEPTH];
    logic [CW-1:0] pers_x [DEPTH];
    logic [CW-1:0] pers_y [DEPTH];
    logic boot_pend_reg;
    dpc_kind_t kind_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    // Bus decode.
    wire setup = psel && !penable;
    wire acc = psel && penable && pready_reg;
    wire wr = acc && pwrite;
    wire hit_ctrl = (paddr == DPC_OFF_CTRL);
    wire hit_cnt = (paddr == DPC_OFF_COUNT);
    wire hit_sel = (paddr == DPC_OFF_SEL);
    wire hit_x = (paddr == DPC_OFF_X);
    wire hit_y = (paddr == DPC_OFF_Y);
    wire hit_cmd = (paddr == DPC_OFF_CMD);
    wire hit_stat = (paddr == DPC_OFF_STAT);
    wire mapped = hit_ctrl | hit_cnt | hit_sel | hit_x | hit_y | hit_cmd | hit_stat;

    // Copy engine hookup.
    wire walk_busy;
    wire walk_last;
    wire [IDX_W-1:0] walk_idx;
    wire busy_any = walk_busy || boot_pend_reg;
    wire cmd_any = wr && hit_cmd && (|pwdata[DPC_CMD_RESTORE_BIT:DPC_CMD_APPLY_BIT]);
    wire walk_go = !walk_busy && (boot_pend_reg || cmd_any);
    wire sel_ok = (sel_reg < stg_cnt_reg);
    wire [IDX_W-1:0] sel_idx = sel_reg[IDX_W-1:0];
    wire stg_edit = wr && !busy_any;
    wire [CNT_W-1:0] cnt_wr = (pwdata > 32'(DEPTH)) ? CNT_W'(DEPTH) : pwdata[CNT_W-1:0];

    dpc_kind_t go_kind;
    assign go_kind = boot_pend_reg ? DPC_KIND_BOOT :
                     pwdata[DPC_CMD_RESTORE_BIT] ? DPC_KIND_RESTORE :
                     pwdata[DPC_CMD_SAVE_BIT] ? DPC_KIND_SAVE : DPC_KIND_APPLY;
    wire [CNT_W-1:0] go_cnt = (go_kind == DPC_KIND_BOOT) ? pers_cnt_reg :
                              (go_kind == DPC_KIND_RESTORE) ? CNT_W'(FACTORY_CNT) :
                              stg_cnt_reg;
    wire go_act = walk_go && (go_kind != DPC_KIND_SAVE);
    wire go_pers = walk_go && (go_kind == DPC_KIND_SAVE || go_kind == DPC_KIND_RESTORE);
    wire go_stg = walk_go && (go_kind == DPC_KIND_RESTORE || go_kind == DPC_KIND_BOOT);

    // Source of each walked entry.
    wire [CW-1:0] fact_x = FACTORY_X[walk_idx*CW +: CW];
    wire [CW-1:0] fact_y = FACTORY_Y[walk_idx*CW +: CW];
    wire [CW-1:0] src_x = (kind_reg == DPC_KIND_RESTORE) ? fact_x :
                          (kind_reg == DPC_KIND_BOOT) ? pers_x[walk_idx] : stg_x[walk_idx];
    wire [CW-1:0] src_y = (kind_reg == DPC_KIND_RESTORE) ? fact_y :
                          (kind_reg == DPC_KIND_BOOT) ? pers_y[walk_idx] : stg_y[walk_idx];
    wire wr_act = walk_busy && (kind_reg != DPC_KIND_SAVE);
    wire wr_pers = walk_busy && (kind_reg == DPC_KIND_SAVE || kind_reg == DPC_KIND_RESTORE);
    wire wr_stg = walk_busy && (kind_reg == DPC_KIND_RESTORE || kind_reg == DPC_KIND_BOOT);

    // Read mux.
    wire [31:0] rd_val =
        hit_ctrl ? 32'({mode_reg, en_reg}) :
        hit_cnt ? 32'(stg_cnt_reg) :
        hit_sel ? 32'(sel_reg) :
        (hit_x && sel_ok) ? 32'(stg_x[sel_idx]) :
        (hit_y && sel_ok) ? 32'(stg_y[sel_idx]) :
        hit_stat ? (32'(act_cnt_reg) << DPC_STAT_ACNT_LSB) | 32'(busy_any) : 32'h0000_0000;

    dpc_copy_walk #(.DEPTH(DEPTH)) u_walk (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(walk_go),
        .busy_reg(walk_busy),
        .idx_reg(walk_idx),
        .last(walk_last)
    );

    // Zero-wait APB answer: pready rises in the first access cycle.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            prdata_reg <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    // Control registers.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_reg <= DPC_EN_RST;
            mode_reg <= DPC_MODE_AVG;
            sel_reg <= '0;
            boot_pend_reg <= 1'b1;
            kind_reg <= DPC_KIND_APPLY;
            act_cnt_reg <= '0;
        end
        else
        begin
            if (wr && hit_ctrl)
            begin
                en_reg <= pwdata[DPC_CTRL_EN_BIT];
                mode_reg <= dpc_mode_t'(pwdata[DPC_CTRL_MODE_BIT]);
            end
            if (stg_edit && hit_sel)
            begin
                sel_reg <= pwdata[CNT_W-1:0];
            end
            if (walk_go)
            begin
                boot_pend_reg <= 1'b0;
                kind_reg <= go_kind;
            end
            if (go_act)
            begin
                act_cnt_reg <= go_cnt;
            end
        end
    end

    // Staging table: software edits and restore or boot refills.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stg_cnt_reg <= '0;
            for (int i = 0; i < DEPTH; i++)
            begin
                stg_x[i] <= '0;
                stg_y[i] <= '0;
            end
        end
        else
        begin
            if (go_stg)
            begin
                stg_cnt_reg <= go_cnt;
            end
            else if (stg_edit && hit_cnt)
            begin
                stg_cnt_reg <= cnt_wr;
            end
            if (wr_stg)
            begin
                stg_x[walk_idx] <= src_x;
                stg_y[walk_idx] <= src_y;
            end
            else if (stg_edit && sel_ok && hit_x)
            begin
                stg_x[sel_idx] <= pwdata[CW-1:0];
            end
            else if (stg_edit && sel_ok && hit_y)
            begin
                stg_y[sel_idx] <= pwdata[CW-1:0];
            end
        end
    end

    // Active table: volatile, cleared by reset and refilled from storage at boot.
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                act_x[i] <= '0;
                act_y[i] <= '0;
            end
        end
        else if (wr_act)
        begin
            act_x[walk_idx] <= src_x;
            act_y[walk_idx] <= src_y;
        end
    end

    // Persistent table: the storage power-on and a factory restore load factory values.
    always_ff @(posedge core_clk or negedge nv_init_n)
    begin
        if (!nv_init_n)
        begin
            pers_cnt_reg <= CNT_W'(FACTORY_CNT);
            for (int i = 0; i < DEPTH; i++)
            begin
                pers_x[i] <= FACTORY_X[i*CW +: CW];
                pers_y[i] <= FACTORY_Y[i*CW +: CW];
            end
        end
        else
        begin
            if (go_pers)
            begin
                pers_cnt_reg <= go_cnt;
            end
            if (wr_pers)
            begin
                pers_x[walk_idx] <= src_x;
                pers_y[walk_idx] <= src_y;
            end
        end
    end

    // Pixel path: coordinates, five-tap window, lookup and replacement.
    logic [CW-1:0] col_reg;
    logic [CW-1:0] row_reg;
    dpc_tap_t tap_reg [DPC_TAPS];
    dpc_pix_t out_reg;
    logic [DEPTH-1:0] hit;

    wire [CW-1:0] cur_x = pix_in.sof ? '0 : col_reg;
    wire [CW-1:0] cur_y = pix_in.sof ? '0 : row_reg;
    wire [CW-1:0] full_x = cur_x + roi_off_x;
    wire [CW-1:0] full_y = cur_y + roi_off_y;
    wire drain = tap_reg[0].vld || tap_reg[1].vld || tap_reg[DPC_CTR].vld;
    wire adv = pix_in.vld || drain;
    dpc_tap_t ctr;
    dpc_tap_t rgt;
    dpc_tap_t lft;
    assign ctr = tap_reg[DPC_CTR];
    assign rgt = tap_reg[0];
    assign lft = tap_reg[DPC_TAPS-1];

    for (genvar e = 0; e < DEPTH; e++)
    begin : g_cmp
        assign hit[e] = (e < act_cnt_reg) && (act_x[e] == ctr.x) && (act_y[e] == ctr.y);
    end

    wire defect = en_reg && ctr.vld && (|hit);
    wire r_ok = rgt.vld && (rgt.y == ctr.y) && (rgt.x == ctr.x + CW'(DPC_NB_DIST));
    wire l_ok = lft.vld && (lft.y == ctr.y) && (lft.x + CW'(DPC_NB_DIST) == ctr.x);
    wire [PW:0] nb_sum = {1'b0, lft.data} + {1'b0, rgt.data};
    wire [PW-1:0] avg = (l_ok && r_ok) ? nb_sum[PW:1] :
                        l_ok ? lft.data : r_ok ? rgt.data : ctr.data;
    wire [PW-1:0] repl = !defect ? ctr.data :
                         (mode_reg == DPC_MODE_HILITE) ? {PW{1'b1}} : avg;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            col_reg <= '0;
            row_reg <= '0;
            out_reg <= '0;
            for (int i = 0; i < DPC_TAPS; i++)
            begin
                tap_reg[i] <= '0;
            end
        end
        else
        begin
            if (pix_in.vld)
            begin
                col_reg <= pix_in.eol ? '0 : cur_x + 1'b1;
                row_reg <= pix_in.eol ? cur_y + 1'b1 : cur_y;
            end
            if (adv)
            begin
                tap_reg[0] <= '{pix_in.vld, pix_in.sof, pix_in.eol, full_x, full_y, pix_in.data};
                for (int i = 1; i < DPC_TAPS; i++)
                begin
                    tap_reg[i] <= tap_reg[i-1];
                end
            end
            out_reg <= '{adv && ctr.vld, ctr.sof, ctr.eol, repl};
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign pix_out = out_reg;

    // Checks.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence cmd_s;
        cmd_any && !busy_any;
    endsequence
    sequence walk_end_s;
        ##[1:1000] walk_last;
    endsequence

    pass_through_a: assert property (adv && ctr.vld && !en_reg |=> pix_out.data == $past(ctr.data))
        else $error("disabled corrector changed a pixel");
    avg_range_a: assert property (adv && defect && mode_reg == DPC_MODE_AVG && l_ok && r_ok
        |=> pix_out.data == $past(nb_sum[PW:1]))
        else $error("average replacement wrong");
    highlight_a: assert property (adv && defect && mode_reg == DPC_MODE_HILITE
        |=> pix_out.vld && pix_out.data == {PW{1'b1}})
        else $error("highlight replacement wrong");
    count_clamp_a: assert property (stg_cnt_reg <= CNT_W'(DEPTH))
        else $error("entry count above table depth");
    coord_write_a: assert property (stg_edit && hit_x && sel_ok
        |=> stg_x[$past(sel_idx)] == $past(pwdata[CW-1:0]))
        else $error("selected X coordinate not written");
    stage_only_a: assert property ($changed(act_cnt_reg) |-> $past(go_act))
        else $error("active count changed without a copy");
    apply_end_a: assert property (cmd_s |-> walk_end_s)
        else $error("table copy did not finish");
    copy_entry_a: assert property (wr_act |=> act_x[$past(walk_idx)] == $past(src_x))
        else $error("active entry not copied");
    save_entry_a: assert property (wr_pers |=> pers_y[$past(walk_idx)] == $past(src_y))
        else $error("persistent entry not saved");
    restore_cnt_a: assert property (walk_go && go_kind == DPC_KIND_RESTORE
        |=> act_cnt_reg == CNT_W'(FACTORY_CNT) && pers_cnt_reg == CNT_W'(FACTORY_CNT))
        else $error("factory restore count wrong");
    boot_load_a: assert property (walk_go && go_kind == DPC_KIND_BOOT
        |=> act_cnt_reg == $past(pers_cnt_reg))
        else $error("boot did not load stored table");
    roi_coord_a: assert property (pix_in.vld |=> tap_reg[0].x == $past(full_x))
        else $error("coordinate lacks readout offset");
endmodule // dpc_top
`default_nettype wire

//--- rtl/dpc_pkg.sv
// Shared constants, register map and carrier types of the defective pixel corrector.
// Assumes one core clock and software access over an APB slave port.
// What this block does
// - One enable: cleared passes pixels unchanged, set replaces every listed pixel.
// - Average mode replaces a listed pixel by the mean of its neighbours.
// - Highlight mode drives the largest pixel value at every listed location.
// - A writable entry count sets how many table entries are valid.
// - The entry selector counts from zero up to count minus one.
// - X and Y coordinate values read and write the selected table entry.
// - Coordinates refer to the full sensor, so readout offsets are added first.
// - Count, selector and coordinate edits touch only the staging table.
// - Apply copies the staging table into the volatile active table.
// - Save writes the staging table to persistent storage; boot loads it back.
// - Factory restore rewrites both active and persistent tables with factory defaults.
// - A separate factory-calibrated list stays available for restore.
// - During a table copy, corrected output may be briefly wrong.
package dpc_pkg;
    localparam int DPC_DEPTH = 16;
    localparam int DPC_PIX_W = 12;
    localparam int DPC_CRD_W = 12;
    localparam int DPC_FACT_CNT = 0;
    localparam int DPC_NB_DIST = 2;
    localparam int DPC_TAPS = 5;
    localparam int DPC_CTR = 2;
    localparam logic [7:0] DPC_OFF_CTRL = 8'h00;
    localparam logic [7:0] DPC_OFF_COUNT = 8'h04;
    localparam logic [7:0] DPC_OFF_SEL = 8'h08;
    localparam logic [7:0] DPC_OFF_X = 8'h0c;
    localparam logic [7:0] DPC_OFF_Y = 8'h10;
    localparam logic [7:0] DPC_OFF_CMD = 8'h14;
    localparam logic [7:0] DPC_OFF_STAT = 8'h18;
    localparam int DPC_CTRL_EN_BIT = 0;
    localparam int DPC_CTRL_MODE_BIT = 1;
    localparam int DPC_CMD_APPLY_BIT = 0;
    localparam int DPC_CMD_SAVE_BIT = 1;
    localparam int DPC_CMD_RESTORE_BIT = 2;
    localparam int DPC_STAT_BUSY_BIT = 0;
    localparam int DPC_STAT_ACNT_LSB = 16;
    localparam logic DPC_EN_RST = 1'b0;

    typedef enum logic {DPC_MODE_AVG = 1'b0, DPC_MODE_HILITE = 1'b1} dpc_mode_t;
    typedef enum logic [1:0] {
        DPC_KIND_APPLY = 2'b00,
        DPC_KIND_SAVE = 2'b01,
        DPC_KIND_RESTORE = 2'b10,
        DPC_KIND_BOOT = 2'b11
    } dpc_kind_t;
    typedef enum logic {DPC_WALK_IDLE = 1'b0, DPC_WALK_RUN = 1'b1} dpc_walk_t;

    typedef struct packed {
        logic vld;
        logic sof;
        logic eol;
        logic [DPC_PIX_W-1:0] data;
    } dpc_pix_t;

    typedef struct packed {
        logic vld;
        logic sof;
        logic eol;
        logic [DPC_CRD_W-1:0] x;
        logic [DPC_CRD_W-1:0] y;
        logic [DPC_PIX_W-1:0] data;
    } dpc_tap_t;
endpackage

//--- rtl/dpc_copy_walk.sv
// Entry walker that steps a table copy through every entry, one per clock.
// Assumes the caller holds the copy source steady while busy_reg is high.
`timescale 1ns/100ps
`default_nettype none
module dpc_copy_walk #(
    parameter int DEPTH = dpc_pkg::DPC_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start,
    output logic busy_reg,
    output logic [$clog2(DEPTH)-1:0] idx_reg,
    output logic last
);
    import dpc_pkg::*;
    localparam logic [$clog2(DEPTH)-1:0] IDX_LAST = ($clog2(DEPTH))'(DEPTH - 1);

    dpc_walk_t state_reg;
    dpc_walk_t state_next;
    logic [$clog2(DEPTH)-1:0] idx_next;

    assign last = (state_reg == DPC_WALK_RUN) && (idx_reg == IDX_LAST);
    assign busy_reg = (state_reg == DPC_WALK_RUN);

    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        unique case (state_reg)
            DPC_WALK_IDLE:
            begin
                if (start)
                begin
                    state_next = DPC_WALK_RUN;
                    idx_next = '0;
                end
            end
            DPC_WALK_RUN:
            begin
                idx_next = idx_reg + 1'b1;
                if (last)
                begin
                    state_next = DPC_WALK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= DPC_WALK_IDLE;
            idx_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
        end
    end
endmodule // dpc_copy_walk
`default_nettype wire

//--- sim/dpc_sensor_model.sv
// Sensor-side model that streams one frame of W by H pixels for each go pulse.
// Assumes go is raised for one clock; idle data toggles so stale values are never reused.
`timescale 1ns/100ps
`default_nettype none
module dpc_sensor_model #(
    parameter int W = 8,
    parameter int H = 2
) (
    input wire logic core_clk,
    input wire logic go,
    output dpc_pkg::dpc_pix_t pix
);
    import dpc_pkg::*;

    initial pix = '0;

    // Row and column set the value, so every pixel of a frame is distinct.
    always @(posedge core_clk)
    begin
        if (go === 1'b1)
        begin
            for (int i = 0; i < W * H; i++)
            begin
                pix <= '{vld: 1'b1, sof: (i == 0), eol: (i % W == W - 1),
                         data: 12'(16 * (i % W) + (i % W) * (i % W) + 100 * (i / W) + 1)};
                @(posedge core_clk);
            end
            pix <= '{vld: 1'b0, sof: 1'b0, eol: 1'b0, data: ~pix.data};
        end
        else
            pix.data <= ~pix.data;
    end
endmodule // dpc_sensor_model
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the defective pixel corrector, driving APB and a pixel stream.
// Assumes dpc_top with two factory entries and the sensor model on its pixel input.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dpc_pkg::*;
    localparam int W = 8;
    localparam logic [DPC_DEPTH*DPC_CRD_W-1:0] FX = {{14{12'h000}}, 12'h006, 12'h002};
    localparam logic [DPC_DEPTH*DPC_CRD_W-1:0] FY = {{14{12'h000}}, 12'h001, 12'h000};
    logic core_clk = 0, reset_n = 0, nv_init_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, d;
    logic pready, pslverr, e;
    dpc_pix_t pix_in, pix_out;
    logic [11:0] ox = '0, oy = '0;
    logic [11:0] outq[$];
    int error_cnt = 0, n_tests = 0, n_act = 2;
    int ex[3] = '{2, 6, 5};
    int ey[3] = '{0, 1, 1};

    dpc_top #(.FACTORY_CNT(2), .FACTORY_X(FX), .FACTORY_Y(FY)) u_dpc_top (
        .core_clk(core_clk), .reset_n(reset_n), .nv_init_n(nv_init_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_in(pix_in),
        .roi_off_x(ox), .roi_off_y(oy), .pix_out(pix_out));
    dpc_sensor_model #(.W(W), .H(2)) u_dpc_sensor_model (
        .core_clk(core_clk), .go(go), .pix(pix_in));

    always #5 core_clk = ~core_clk;
    always @(negedge core_clk) if (pix_out.vld === 1'b1) outq.push_back(pix_out.data);

    // Pixel value that the sensor model sends at column x of row y; the square term keeps
    // the mean of the two neighbours apart from the centre value.
    function automatic int pv(input int x, input int y);
        return 16 * x + x * x + 100 * y + 1;
    endfunction

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds the request until pready is seen high, then releases after that edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20)
        begin
            chk("pready", 1, 0);
            stop_test;
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        xfer(1'b1, a, wd);
    endtask

    task automatic wait_idle;
        for (int k = 0; k < 40; k++)
        begin
            xfer(1'b0, DPC_OFF_STAT, '0);
            if (d[DPC_STAT_BUSY_BIT] === 1'b0) return;
        end
        chk("busy timeout", 0, 1);
        stop_test;
    endtask

    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        nv_init_n <= 1'b1;
        xfer(1'b0, DPC_OFF_STAT, '0);
        chk("boot busy", 1, {31'h0, d[DPC_STAT_BUSY_BIT]});
        wait_idle;
    endtask

    // Streams one frame and compares every output pixel in order against the table.
    task automatic frame_chk(input logic en, input logic hl);
        int x, y, k, v;
        logic hit;
        outq.delete();
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (k = 0; k < 60 && outq.size() < 2 * W; k++) @(posedge core_clk);
        chk("pixel count", 2 * W, outq.size());
        if (outq.size() != 2 * W) stop_test;
        for (int i = 0; i < outq.size(); i++)
        begin
            x = i % W;
            y = i / W;
            v = pv(x, y);
            hit = 1'b0;
            for (int j = 0; j < n_act; j++) if (ex[j] == x + ox && ey[j] == y + oy) hit = 1'b1;
            if (en && hit && hl) v = 12'hfff;
            else if (en && hit && x >= 2 && x + 2 < W) v = (pv(x - 2, y) + pv(x + 2, y)) / 2;
            else if (en && hit && x >= 2) v = pv(x - 2, y);
            else if (en && hit) v = pv(x + 2, y);
            chk("pixel", 32'(v), {20'h0, outq[i]});
        end
    endtask

    task automatic t_boot;
        xfer(1'b0, DPC_OFF_CTRL, '0);
        chk("ctrl reset", 0, d);
        xfer(1'b0, DPC_OFF_COUNT, '0);
        chk("factory count", 2, d);
        frame_chk(1'b0, 1'b0);
        xfer(1'b0, 8'h1c, '0);
        chk("unmapped err", 1, {31'h0, e});
        chk("unmapped data", 0, d);
    endtask

    task automatic t_edit;
        wr(DPC_OFF_CTRL, 32'h1);
        wr(DPC_OFF_COUNT, 32'h14);
        xfer(1'b0, DPC_OFF_COUNT, '0);
        chk("count clamp", 16, d);
        wr(DPC_OFF_COUNT, 32'h3);
        wr(DPC_OFF_SEL, 32'h2);
        wr(DPC_OFF_X, 32'h5);
        wr(DPC_OFF_Y, 32'h1);
        xfer(1'b0, DPC_OFF_X, '0);
        chk("coord x", 5, d);
        xfer(1'b0, DPC_OFF_Y, '0);
        chk("coord y", 1, d);
        wr(DPC_OFF_SEL, 32'h3);
        wr(DPC_OFF_X, 32'h9);
        xfer(1'b0, DPC_OFF_X, '0);
        chk("out of range x", 0, d);
        frame_chk(1'b1, 1'b0);
        wr(DPC_OFF_CMD, 32'h1);
        wait_idle;
        chk("active count", 3, {27'h0, d[20:16]});
        n_act = 3;
        frame_chk(1'b1, 1'b0);
        wr(DPC_OFF_CTRL, 32'h3);
        frame_chk(1'b1, 1'b1);
        wr(DPC_OFF_CTRL, 32'h1);
        ox <= 12'h002;
        oy <= 12'h001;
        frame_chk(1'b1, 1'b0);
        ox <= 12'h000;
        oy <= 12'h000;
    endtask

    task automatic t_persist;
        wr(DPC_OFF_COUNT, 32'h1);
        wr(DPC_OFF_CMD, 32'h1);
        wait_idle;
        wr(DPC_OFF_CMD, 32'h2);
        wait_idle;
        n_act = 1;
        frame_chk(1'b1, 1'b0);
        do_reset;
        chk("boot count", 1, {27'h0, d[20:16]});
        wr(DPC_OFF_CTRL, 32'h1);
        frame_chk(1'b1, 1'b0);
        wr(DPC_OFF_CMD, 32'h4);
        wait_idle;
        chk("restore count", 2, {27'h0, d[20:16]});
        n_act = 2;
        frame_chk(1'b1, 1'b0);
        do_reset;
        xfer(1'b0, DPC_OFF_COUNT, '0);
        chk("restored stored count", 2, d);
        wr(DPC_OFF_CTRL, 32'h1);
        frame_chk(1'b1, 1'b0);
    endtask

    initial
    begin
        do_reset;
        t_boot;
        t_edit;
        t_persist;
        stop_test;
    end
endmodule // tb
`default_nettype wire
